// *** common/bcx_defs.vh ***
/*
 * constants for the baseline instruction executer: opcode fields, status bits,
 * phase counts and reset values.
 * assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef BCX_DEFS_VH
`define BCX_DEFS_VH

// phases per instruction cycle
`define BCX_PHASES 3'h4
`define BCX_PHASE_LAST 2'h3
`define BCX_PHASE_ZERO 2'h0
`define BCX_PHASE_STEP 2'h1

// opcode fields
`define BCX_OP_MSB 11
`define BCX_F_MSB 4
`define BCX_B_MSB 7
`define BCX_B_LSB 5
`define BCX_D_BIT 5
`define BCX_K_MSB 7
`define BCX_CALL_LSB 8
`define BCX_CLEAR_FILE_OP_LSB 5
`define BCX_SUB_LSB 6

// encodings
`define BCX_CALL_NIB 4'h9
`define BCX_CLEAR_FILE_OP_HI 7'h03
`define BCX_CLEAR_ACCUMULATOR_OP_WORD 12'h040
`define BCX_KICK_WORD 12'h004
`define BCX_SLEEP_WORD 12'h003
`define BCX_SUB_HI 6'h02

// status bit positions
`define BCX_ST_C 0
`define BCX_ST_DC 1
`define BCX_ST_Z 2
`define BCX_ST_PD 3
`define BCX_ST_TO 4
`define BCX_ST_PAGE_LO 5
`define BCX_ST_PAGE_HI 6
`define BCX_ST_WAKE 7

// reset values
`define BCX_STATUS_RST 8'h18
`define BCX_ZERO8 8'h00
`define BCX_ZERO11 11'h000
`define BCX_ZERO5 5'h00
`define BCX_NOP_WORD 12'h000
`define BCX_ONE_PC 11'h001
`define BCX_MASK_ONE 8'h01

`endif

// *** verilog/bcx_phase_gen.v ***
/*
 * four-phase generator: splits the oscillator into instruction cycles.
 * assumes one clock, asynchronous active-low reset; halts while asleep.
 */
`timescale 1ns/1ps
`include "bcx_defs.vh"

module bcx_phase_gen (
  input wire clock_i,
  input wire reset_n_i,
  input wire halt_i,
  output reg [1:0] phase_o,
  output reg cycle_end_o
);

  // phase counter; stopping it models the halted oscillator
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_o <= `BCX_PHASE_ZERO;
      cycle_end_o <= 1'b0;
    end else if (halt_i) begin
      phase_o <= `BCX_PHASE_ZERO;
      cycle_end_o <= 1'b0;
    end else begin
      phase_o <= phase_o + `BCX_PHASE_STEP;
      cycle_end_o <= (phase_o == (`BCX_PHASE_LAST - `BCX_PHASE_STEP));
    end
  end

endmodule // bcx_phase_gen

// *** verilog/bcx_alu.v ***
/*
 * subtract unit: file value minus accumulator with carry, digit carry, zero.
 * assumes operands are stable for the whole instruction cycle.
 */
`timescale 1ns/1ps
`include "bcx_defs.vh"

module bcx_alu (
  input wire [7:0] file_i,
  input wire [7:0] acc_i,
  output wire [7:0] diff_o,
  output wire carry_o,
  output wire dcarry_o,
  output wire zero_o
);

  wire [8:0] full_sum;
  wire [4:0] low_sum;

  // two's complement: f + ~w + 1, carry means no borrow
  assign full_sum = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
  assign low_sum = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
  assign diff_o = full_sum[7:0];
  assign carry_o = full_sum[8];
  assign dcarry_o = low_sum[4];
  assign zero_o = (full_sum[7:0] == `BCX_ZERO8);

endmodule // bcx_alu

// *** verilog/bcx_core.v ***
/*
 * baseline core execute stage: decodes a 12-bit word and runs call, clear
 * file, clear accumulator, kick watchdog, sleep and subtract; drives a bit mask.
 * assumes program memory answers the fetch address within one instruction
 * cycle, and the file register file is read combinationally at file_addr_o.
 */
`timescale 1ns/1ps
`include "bcx_defs.vh"

// Overview of operation
// - one cycle each; branch or call takes two
// - instruction cycle equals four oscillator periods
// - destination bit: zero accumulator, one file
// - call copies status page bits, clears pc8
// - call nibble 1001 loads literal into pc
// - call pushes next address; two cycles
// - clear file zeroes register, sets zero flag
// - clear accumulator zeroes it, sets zero
// - kick watchdog clears counter, sets flags
// - sleep clears watchdog, prescaler, sets timeout
// - sleep clears powerdown, keeps wake flag
// - sleep halts oscillator, enters low power
// - bit field selects bit within register
// - file field selects one of 32
module bcx_core (
  input wire clock_i,
  input wire reset_n_i,
  input wire [11:0] instr_i,
  input wire [7:0] file_rdata_i,
  input wire prescaler_to_wdog_i,
  input wire wake_i,
  input wire pin_change_wake_flag_i,
  output reg [10:0] pc_o,
  output reg [10:0] stack_top_o,
  output reg [7:0] acc_o,
  output reg [7:0] status_o,
  output reg [4:0] file_addr_o,
  output reg [7:0] file_wdata_o,
  output reg file_we_o,
  output reg [7:0] bit_mask_o,
  output reg watchdog_clear_o,
  output reg prescaler_clear_o,
  output reg sleep_o,
  output reg cycle_end_o
);

  localparam RUN = 2'h0;
  localparam FLUSH = 2'h1;
  localparam SLEEP = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [11:0] ir_q;
  wire [1:0] phase;
  wire cyc_end;
  wire [7:0] diff;
  wire sub_c;
  wire sub_dc;
  wire sub_z;

  // decoded instruction classes
  wire is_call;
  wire is_clear_file_op;
  wire is_clear_accumulator_op;
  wire is_kick_watchdog_op;
  wire is_sleep;
  wire is_subtract_acc_from_file_op;
  wire dest_file;
  wire [4:0] f_field;
  wire [2:0] b_field;

  bcx_phase_gen u_phase (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .halt_i(state_q == SLEEP),
    .phase_o(phase),
    .cycle_end_o(cyc_end)
  );

  bcx_alu u_alu (
    .file_i(file_rdata_i),
    .acc_i(acc_o),
    .diff_o(diff),
    .carry_o(sub_c),
    .dcarry_o(sub_dc),
    .zero_o(sub_z)
  );

  assign is_call = (ir_q[`BCX_OP_MSB:`BCX_CALL_LSB] == `BCX_CALL_NIB);
  assign is_clear_file_op = (ir_q[`BCX_OP_MSB:`BCX_CLEAR_FILE_OP_LSB] == `BCX_CLEAR_FILE_OP_HI);
  assign is_clear_accumulator_op = (ir_q == `BCX_CLEAR_ACCUMULATOR_OP_WORD);
  assign is_kick_watchdog_op = (ir_q == `BCX_KICK_WORD);
  assign is_sleep = (ir_q == `BCX_SLEEP_WORD);
  assign is_subtract_acc_from_file_op = (ir_q[`BCX_OP_MSB:`BCX_SUB_LSB] == `BCX_SUB_HI);
  assign dest_file = ir_q[`BCX_D_BIT];
  assign f_field = ir_q[`BCX_F_MSB:0];
  assign b_field = ir_q[`BCX_B_MSB:`BCX_B_LSB];

  // next state: a call spends a flush cycle discarding the prefetched word
  always @* begin
    state_d = state_q;
    case (state_q)
      RUN: begin
        if (cyc_end && is_call) begin
          state_d = FLUSH;
        end else if (cyc_end && is_sleep) begin
          state_d = SLEEP;
        end
      end
      FLUSH: begin
        if (cyc_end) begin
          state_d = RUN;
        end
      end
      SLEEP: begin
        if (wake_i) begin
          state_d = RUN;
        end
      end
      default: begin
        state_d = RUN;
      end
    endcase
  end

  // state, fetch and program counter
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= RUN;
      ir_q <= `BCX_NOP_WORD;
      pc_o <= `BCX_ZERO11;
      stack_top_o <= `BCX_ZERO11;
      sleep_o <= 1'b0;
      cycle_end_o <= 1'b0;
    end else begin
      state_q <= state_d;
      sleep_o <= (state_d == SLEEP);
      cycle_end_o <= cyc_end;
      if (cyc_end && state_q == RUN && is_call) begin
        stack_top_o <= pc_o; // pc already points past the call
        pc_o <= {status_o[`BCX_ST_PAGE_HI], status_o[`BCX_ST_PAGE_LO], 1'b0,
                 ir_q[`BCX_K_MSB:0]};
        ir_q <= `BCX_NOP_WORD; // prefetch is thrown away
      end else if (cyc_end && state_q != SLEEP) begin
        ir_q <= instr_i;
        pc_o <= pc_o + `BCX_ONE_PC;
      end
    end
  end

  // accumulator, status flags and write data change at cycle end only; wake bit, file address and bit mask every clock
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_o <= `BCX_ZERO8;
      status_o <= `BCX_STATUS_RST;
      file_addr_o <= `BCX_ZERO5;
      file_wdata_o <= `BCX_ZERO8;
      file_we_o <= 1'b0;
      bit_mask_o <= `BCX_MASK_ONE; // one-hot of the nop word's zero bit field
      watchdog_clear_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
    end else begin
      file_we_o <= 1'b0;
      watchdog_clear_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
      file_addr_o <= f_field;
      bit_mask_o <= `BCX_MASK_ONE << b_field;
      status_o[`BCX_ST_WAKE] <= pin_change_wake_flag_i; // mirrors, never written
      if (cyc_end && state_q == RUN) begin
        if (is_clear_file_op) begin
          file_wdata_o <= `BCX_ZERO8;
          file_we_o <= 1'b1;
          status_o[`BCX_ST_Z] <= 1'b1;
        end else if (is_clear_accumulator_op) begin
          acc_o <= `BCX_ZERO8;
          status_o[`BCX_ST_Z] <= 1'b1;
        end else if (is_kick_watchdog_op) begin
          watchdog_clear_o <= 1'b1;
          prescaler_clear_o <= prescaler_to_wdog_i;
          status_o[`BCX_ST_TO] <= 1'b1;
          status_o[`BCX_ST_PD] <= 1'b1;
        end else if (is_sleep) begin
          watchdog_clear_o <= 1'b1;
          prescaler_clear_o <= 1'b1;
          status_o[`BCX_ST_TO] <= 1'b1;
          status_o[`BCX_ST_PD] <= 1'b0;
        end else if (is_subtract_acc_from_file_op) begin
          status_o[`BCX_ST_C] <= sub_c;
          status_o[`BCX_ST_DC] <= sub_dc;
          status_o[`BCX_ST_Z] <= sub_z;
          if (dest_file) begin
            file_wdata_o <= diff;
            file_we_o <= 1'b1;
          end else begin
            acc_o <= diff;
          end
        end
      end
    end
  end

endmodule // bcx_core

// *** verification/bcx_core_properties.sv ***
/* checker for bcx_core: cycle spacing, sleep, watchdog and flag effects.
   assumes it is bound to bcx_core and sees only its ports. */
`timescale 1ns/1ps
module bcx_core_properties (
  input wire clock_i,
  input wire reset_n_i,
  input wire prescaler_to_wdog_i,
  input wire pin_change_wake_flag_i,
  input wire [10:0] pc_o,
  input wire [7:0] status_o,
  input wire [7:0] file_wdata_o,
  input wire file_we_o,
  input wire [7:0] bit_mask_o,
  input wire watchdog_clear_o,
  input wire prescaler_clear_o,
  input wire sleep_o,
  input wire cycle_end_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // sleep exit may restart the phase count, so spacing is only checked while awake
  a_cycle_four_clk: assert property (cycle_end_o && !sleep_o |=>
    !cycle_end_o [*3] ##1 (cycle_end_o || sleep_o)) else $error("cycle spacing");
  a_sleep_halts_core: assert property (sleep_o && $past(sleep_o, 2) |->
    !cycle_end_o && $stable(pc_o)) else $error("core runs in sleep");
  a_sleep_sets_flags: assert property ($rose(sleep_o) |-> status_o[4] && !status_o[3]
    && (watchdog_clear_o || $past(watchdog_clear_o))
    && (prescaler_clear_o || $past(prescaler_clear_o))) else $error("sleep effects");
  a_kick_sets_flags: assert property (watchdog_clear_o && !sleep_o |->
    ##[0:4] (status_o[4] && status_o[3])) else $error("kick flags");
  a_kick_prescaler: assert property (watchdog_clear_o && !sleep_o |->
    prescaler_clear_o == $past(prescaler_to_wdog_i)) else $error("kick prescaler");
  a_wake_flag_mirror: assert property ($past(reset_n_i) |->
    status_o[7] == $past(pin_change_wake_flag_i)) else $error("wake flag");
  a_write_one_clk: assert property (file_we_o |=> !file_we_o) else $error("write pulse");
  a_zero_on_write: assert property (file_we_o |-> status_o[2] == (file_wdata_o == 8'h00))
    else $error("zero flag");
  a_mask_one_hot: assert property ($onehot(bit_mask_o)) else $error("bit mask");
endmodule // bcx_core_properties
bind bcx_core bcx_core_properties u_props (.clock_i, .reset_n_i, .prescaler_to_wdog_i,
  .pin_change_wake_flag_i, .pc_o, .status_o, .file_wdata_o, .file_we_o, .bit_mask_o,
  .watchdog_clear_o, .prescaler_clear_o, .sleep_o, .cycle_end_o);

// *** verification/bcx_mem_model.sv ***
/* program memory and 32-entry file register model facing bcx_core.
   assumes the bench loads both arrays before reset is released. */
`timescale 1ns/1ps
module bcx_mem_model (
  input wire clock_i,
  input wire [10:0] pc_i,
  input wire [4:0] file_addr_i,
  input wire [7:0] file_wdata_i,
  input wire file_we_i,
  output wire [11:0] instr_o,
  output wire [7:0] file_rdata_o
);
  reg [11:0] rom_q [0:2047];
  reg [7:0] ram_q [0:31];
  // reads are combinational, as the core expects its operand within the cycle
  assign instr_o = rom_q[pc_i];
  assign file_rdata_o = ram_q[file_addr_i];
  // write on the core's one-clock strobe
  always @(posedge clock_i) begin
    if (file_we_i) begin
      ram_q[file_addr_i] <= file_wdata_i;
    end
  end
endmodule // bcx_mem_model

// *** verification/bcx_core_tb.sv ***
/* self-checking bench for bcx_core: runs short programs that end in sleep.
   assumes the memory model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module bcx_core_tb;
  reg clock_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg presc_i = 1'b0;
  reg wake_i = 1'b0;
  reg pin_i = 1'b0;
  wire [11:0] instr;
  wire [7:0] rdata, acc_o, status_o, wdata, mask;
  wire [10:0] pc_o, stack_top_o;
  wire [4:0] faddr;
  wire we, wd_clr, ps_clr, sleep_o, cyc;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i;
  bcx_core u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_i(instr),
    .file_rdata_i(rdata), .prescaler_to_wdog_i(presc_i), .wake_i(wake_i),
    .pin_change_wake_flag_i(pin_i), .pc_o(pc_o), .stack_top_o(stack_top_o), .acc_o(acc_o),
    .status_o(status_o), .file_addr_o(faddr), .file_wdata_o(wdata), .file_we_o(we),
    .bit_mask_o(mask), .watchdog_clear_o(wd_clr), .prescaler_clear_o(ps_clr),
    .sleep_o(sleep_o), .cycle_end_o(cyc));
  bcx_mem_model u_mem (.clock_i(clock_i), .pc_i(pc_o), .file_addr_i(faddr),
    .file_wdata_i(wdata), .file_we_i(we), .instr_o(instr), .file_rdata_o(rdata));
  // 100 MHz oscillator
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task close_out;
    begin
      $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task cmp(input [10:0] got, input [10:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // bounded wait counting clocks to sleep, sampled off the edge, then let writes land
  task run_to_sleep(input [10:0] clocks);
    begin
      i = 0;
      while (sleep_o !== 1'b1 && i < 200) begin
        @(posedge clock_i);
        #1;
        i = i + 1;
      end
      cmp({10'h000, sleep_o}, 11'h001);
      cmp(i[10:0], clocks);
      repeat (3) @(posedge clock_i);
      #1;
    end
  endtask
  task wake_up;
    begin
      @(posedge clock_i);
      #1 wake_i = 1'b1;
      @(posedge clock_i);
      #1 wake_i = 1'b0;
    end
  endtask
  // the subtract results and the call target are chosen so each check is distinct
  initial begin
    for (i = 0; i < 2048; i = i + 1) u_mem.rom_q[i] = 12'h000;
    for (i = 0; i < 32; i = i + 1) u_mem.ram_q[i] = 8'h00;
    u_mem.ram_q[8] = 8'h03;
    u_mem.ram_q[10] = 8'h05;
    u_mem.rom_q[0] = 12'h088;
    u_mem.rom_q[1] = 12'h0a9;
    u_mem.rom_q[2] = 12'h003;
    u_mem.rom_q[3] = 12'h069;
    u_mem.rom_q[4] = 12'h004;
    u_mem.rom_q[5] = 12'h040;
    u_mem.rom_q[6] = 12'h920;
    u_mem.rom_q[32] = 12'h003;
    u_mem.rom_q[33] = 12'h004;
    u_mem.rom_q[34] = 12'h08a;
    u_mem.rom_q[35] = 12'h0aa;
    u_mem.rom_q[36] = 12'h003;
    repeat (10) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    // nop slot plus three instructions, four clocks each
    run_to_sleep(11'h010);
    cmp({3'h0, acc_o}, 11'h003);
    cmp({3'h0, u_mem.ram_q[9]}, 11'h0fd);
    cmp({6'h00, status_o[4:0]}, 11'h010);
    cmp({3'h0, mask}, 11'h008);
    cmp({6'h00, faddr}, 11'h009);
    $display("test subtract done");
    wake_up;
    // three one-cycle words, a two-cycle call, then sleep
    run_to_sleep(11'h018);
    cmp({3'h0, u_mem.ram_q[9]}, 11'h000);
    cmp({3'h0, acc_o}, 11'h000);
    cmp({6'h00, status_o[4:0]}, 11'h014);
    cmp(stack_top_o, 11'h007);
    cmp(pc_o, 11'h022);
    $display("test clear and call done");
    presc_i = 1'b1;
    pin_i = 1'b1;
    wake_up;
    run_to_sleep(11'h010);
    cmp({3'h0, acc_o}, 11'h005);
    cmp({3'h0, u_mem.ram_q[10]}, 11'h000);
    cmp({3'h0, status_o}, 11'h097);
    $display("test kick and wake flag done");
    close_out;
  end
  // whole run needs well under 1000 cycles
  initial begin
    #200000;
    miscompares = miscompares + 1;
    $display("MISMATCH at %0t: run did not finish", $time);
    close_out;
  end
endmodule // bcx_core_tb
